// ==== bench/dtl_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module dtl_host
   import dtl_pkg::*;
(
   output var logic sclk,
   output var logic fsync_n,
   output var logic serial_data_in
);
   logic [dtl_pkg::WORD_W-1:0] w;

   // Link idles with its clock still and the frame high
   initial
   begin
      sclk = 1'b0;
      fsync_n = 1'b1;
      serial_data_in = 1'b1;
   end

   // One link clock pulse of 30 ns
   task automatic pulse;
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
   endtask : pulse

   // Lead pulse, then one frame, MSB first, data moved on falling edges
   task automatic send(input logic [dtl_pkg::WORD_W-1:0] word);
      w = word;
      if (w[CMD_HI:CMD_LO] == CMD_CTRL)
      begin
         w[2] = 1'b0;
         w[0] = 1'b0;
         w[CB_MODE] = w[CB_MODE] & ~w[CB_SOE];
      end
      pulse();
      fsync_n = 1'b0;
      for (int i = WORD_W - 1; i >= 0; i--)
      begin
         serial_data_in = w[i];
         pulse();
      end
      fsync_n = 1'b1;
      serial_data_in = ~w[0]; // Released line shows no stale bit
   endtask : send

   // Whole tuning word: low half first, then high half to the same code
   task automatic send28(input logic [1:0] cmd, input logic [dtl_pkg::ACC_W-1:0] v);
      send({cmd, v[13:0]});
      send({cmd, v[27:14]});
   endtask : send28
endmodule : dtl_host
`default_nettype wire

// ==== bench/dtl_top_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module dtl_top_props
   import dtl_pkg::*;
#(
   parameter int ACC_BITS = dtl_pkg::ACC_W,
   parameter int DAC_BITS = dtl_pkg::DAC_W
)
(
   input wire logic                        clk,
   input wire logic                        nrst,
   input wire logic                        ce,
   input wire logic                        fsync_n,
   input wire logic                        freq_select_pin,
   input wire logic                        phase_select_pin,
   input wire logic [dtl_pkg::DAC_W-1:0]   dac_code,
   input wire logic                        sign_out,
   input wire logic                        sign_out_oe,
   input wire logic [dtl_pkg::ACC_W-1:0]   selected_tuning_value,
   input wire logic [dtl_pkg::PHASE_W-1:0] selected_phase_value
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // Idle values straight after reset
   rst_out_a: assert property ($rose(nrst) |-> dac_code == DAC_MID && !sign_out_oe)
      else $error("outputs not idle after reset");
   rst_sel_a: assert property ($rose(nrst) |-> selected_tuning_value == '0 && selected_phase_value == '0)
      else $error("selected values not zero after reset");
   idle_sign_low_a: assert property (!sign_out_oe |-> !sign_out)
      else $error("sign pin active while disabled");

   // Accumulator steps only when enabled and by the selected word
   dac_freeze_a: assert property (!ce |=> $stable(dac_code))
      else $error("dac code moved while halted");
   zero_step_a: assert property ((fsync_n && selected_tuning_value == '0
      && $stable(selected_phase_value))[*7] ##1 $stable(selected_phase_value) |-> $stable(dac_code))
      else $error("dac code moved with zero tuning");

   // Changes need a frame or a pin change as cause
   oe_cause_a: assert property ($changed(sign_out_oe) |-> !$past(fsync_n, 8))
      else $error("sign enable changed without a frame");
   tune_cause_a: assert property ($changed(selected_tuning_value) |-> !$past(fsync_n, 8)
      || $past(freq_select_pin, 1) != $past(freq_select_pin, 7))
      else $error("tuning selection changed without cause");
   phase_cause_a: assert property ($changed(selected_phase_value) |-> !$past(fsync_n, 8)
      || $past(phase_select_pin, 1) != $past(phase_select_pin, 7))
      else $error("phase selection changed without cause");
endmodule : dtl_top_props
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import dtl_pkg::*;
   logic             clk;
   logic             nrst;
   logic             ce;
   logic             sclk;
   logic             fsync_n;
   logic             sdi;
   logic             fp;
   logic             pp;
   logic             comp_in;
   logic             so;
   logic             oe;
   logic [DAC_W-1:0] dac;
   logic [ACC_W-1:0] tv;
   logic [PHASE_W-1:0] pv;
   logic [ACC_W-1:0] wa;
   logic [ACC_W-1:0] wb;
   logic [31:0]      rs;
   int               bad_count;
   int               num_checks;
   int               s;
   int               m;

   dtl_top dut (.clk, .nrst, .ce, .sclk, .fsync_n, .serial_data_in(sdi), .freq_select_pin(fp),
      .phase_select_pin(pp), .comp_in, .dac_code(dac), .sign_out(so), .sign_out_oe(oe),
      .selected_tuning_value(tv), .selected_phase_value(pv));
   dtl_host u_host (.sclk, .fsync_n, .serial_data_in(sdi));

   // Master clock, 25 ns
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs

   function automatic logic [WORD_W-1:0] bt(input int n);
      return 16'h0001 << n;
   endfunction : bt

   function automatic logic near(input int a, input int b);
      return a <= b + 2 && b <= a + 2;
   endfunction : near

   task automatic chk(input logic [ACC_W-1:0] got, input logic [ACC_W-1:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   // One word, then time for it to cross and land
   task automatic wr(input logic [WORD_W-1:0] w);
      u_host.send(w);
      cyc(8);
   endtask : wr

   // Edges of the sign pin and of the dac code top bit
   task automatic edges(output int es, output int em);
      logic ls;
      logic lm;
      es = 0;
      em = 0;
      ls = so;
      lm = dac[DAC_W-1];
      repeat (256)
      begin
         @(negedge clk);
         es += int'(so !== ls);
         em += int'(dac[DAC_W-1] !== lm);
         ls = so;
         lm = dac[DAC_W-1];
      end
   endtask : edges

   // Cut a hang short
   initial
   begin
      #200000;
      bad_count++;
      report_and_stop();
   end

   // Main sequence
   initial
   begin
      nrst = 1'b0;
      ce = 1'b1;
      fp = 1'b0;
      pp = 1'b0;
      comp_in = 1'b0;
      rs = 32'h0000ad34;
      bad_count = 0;
      num_checks = 0;
      u_host.pulse();
      repeat (20) @(negedge clk);
      nrst <= 1'b1;
      cyc(2);
      chk(oe, 1'b0);
      chk(tv, '0);
      // Whole load of word a, seen after each half
      rs = xs(rs);
      wa = rs[27:0];
      wr(bt(CB_FULL));
      wr({CMD_FREQ_A, wa[13:0]});
      chk(tv, {14'h0, wa[13:0]});
      wr({CMD_FREQ_A, wa[27:14]});
      chk(tv, wa);
      // Word b loaded while a stays in use
      rs = xs(rs);
      wb = rs[27:0];
      u_host.send28(CMD_FREQ_B, wb);
      cyc(8);
      chk(tv, wa);
      // Half writes to word b
      rs = xs(rs);
      wr(bt(CB_HALF) | bt(CB_TSEL));
      wr({CMD_FREQ_B, rs[13:0]});
      wb[27:14] = rs[13:0];
      chk(tv, wb);
      wr(bt(CB_TSEL));
      wr({CMD_FREQ_B, rs[27:14]});
      wb[13:0] = rs[27:14];
      chk(tv, wb);
      // Both offsets, then each select pair from the control bits
      rs = xs(rs);
      wr({CMD_PHASE, 2'h0, rs[11:0]});
      wr({CMD_PHASE, 2'h2, rs[23:12]});
      for (int i = 0; i < 4; i++)
      begin
         wr((i[0] ? bt(CB_TSEL) : 16'h0) | (i[1] ? bt(CB_PSEL) : 16'h0));
         chk(tv, i[0] ? wb : wa);
         chk(pv, i[1] ? rs[23:12] : rs[11:0]);
      end
      // Each select pair from the pins
      wr(bt(CB_SRC));
      for (int i = 0; i < 4; i++)
      begin
         fp <= i[0];
         pp <= i[1];
         cyc(6);
         chk(tv, i[0] ? wb : wa);
         chk(pv, i[1] ? rs[23:12] : rs[11:0]);
      end
      // Comparator on the sign pin, pins left steady
      wr(bt(CB_SOE) | bt(CB_SSRC) | bt(CB_DIV));
      chk(oe, 1'b1);
      repeat (16)
      begin
         rs = xs(rs);
         comp_in <= rs[0];
         cyc(5);
         chk(so, comp_in);
      end
      // Word a of 2^22 gives a top bit period of 64 cycles
      wr(bt(CB_FULL));
      u_host.send28(CMD_FREQ_A, 28'h0400000);
      for (int d = 0; d < 2; d++)
      begin
         wr(bt(CB_SOE) | (d[0] ? bt(CB_DIV) : 16'h0));
         edges(s, m);
         chk(near(m, 8), 1'b1);
         chk(near(d[0] ? s : 2 * s, m), 1'b1);
      end
      // Triangle: linear steps of 32 codes at a phase step of 64
      wr(bt(CB_MODE));
      chk(oe, 1'b0);
      chk(so, 1'b0);
      s = 0;
      m = int'(dac);
      repeat (256)
      begin
         @(negedge clk);
         s += int'(int'(dac) <= m + 33 && m <= int'(dac) + 33);
         m = int'(dac);
      end
      chk(s > 250, 1'b1);
      // Halt the datapath for a while
      ce <= 1'b0;
      cyc(10);
      ce <= 1'b1;
      cyc(4);
      report_and_stop();
   end
endmodule : tb_top

bind dtl_top dtl_top_props #(.ACC_BITS(ACC_BITS), .DAC_BITS(DAC_BITS)) u_props (
   .clk, .nrst, .ce, .fsync_n, .freq_select_pin, .phase_select_pin, .dac_code,
   .sign_out, .sign_out_oe, .selected_tuning_value, .selected_phase_value);
`default_nettype wire

// ==== hw/dtl_pkg.sv ====
package dtl_pkg;
   // Link word and datapath widths
   localparam int WORD_W  = 16;
   localparam int ACC_W   = 28;
   localparam int HALF_W  = 14;
   localparam int PHASE_W = 12;
   localparam int DAC_W   = 10;
   localparam int CNT_W   = 4;

   // Command codes in the top two bits of a link word
   localparam logic [1:0] CMD_CTRL   = 2'h0;
   localparam logic [1:0] CMD_FREQ_A = 2'h1;
   localparam logic [1:0] CMD_FREQ_B = 2'h2;
   localparam logic [1:0] CMD_PHASE  = 2'h3;
   localparam int CMD_HI = 15;
   localparam int CMD_LO = 14;

   // Control word bit positions, and the register select bit of a phase word
   localparam int CB_FULL  = 13;
   localparam int CB_HALF  = 12;
   localparam int CB_TSEL  = 11;
   localparam int CB_PSEL  = 10;
   localparam int CB_SRC   = 9;
   localparam int CB_SOE   = 5;
   localparam int CB_SSRC  = 4;
   localparam int CB_DIV   = 3;
   localparam int CB_MODE  = 1;
   localparam int PH_REG   = 13;

   // Values after reset, and the count of the last bit of a frame
   localparam logic [WORD_W-1:0]  CTRL_RST  = 16'h0000;
   localparam logic [ACC_W-1:0]   FREQ_RST  = 28'h0000000;
   localparam logic [PHASE_W-1:0] PHASE_RST = 12'h000;
   localparam logic [CNT_W-1:0]   CNT_LAST  = 4'hf;

   // Sine shaping constants
   localparam logic [DAC_W-1:0] DAC_MID    = 10'h200;
   localparam int               SINE_SHIFT = 11;

   // Full-width load sequencing
   typedef enum logic [1:0] {
      DTL_LOAD_IDLE,
      DTL_LOAD_HIGH_A,
      DTL_LOAD_HIGH_B
   } dtl_load_e;
endpackage : dtl_pkg

// ==== hw/dtl_serial_rx.sv ====
`timescale 1ns/100ps
`default_nettype none
module dtl_serial_rx
   import dtl_pkg::*;
(
   input  wire logic                      sclk,
   input  wire logic                      nrst,
   input  wire logic                      fsync_n,
   input  wire logic                      data_in,
   output var  logic [dtl_pkg::WORD_W-1:0] word_o,
   output var  logic                      word_tgl_o
);
   import dtl_pkg::*;

   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cnt_d;
   logic [WORD_W-2:0] sh_q;
   logic [WORD_W-2:0] sh_d;
   logic [WORD_W-1:0] word_q;
   logic [WORD_W-1:0] word_d;
   logic              tgl_q;
   logic              tgl_d;

   // Shift in MSB first while framed; sixteenth bit completes a word
   always_comb
   begin
      cnt_d  = cnt_q;
      sh_d   = sh_q;
      word_d = word_q;
      tgl_d  = tgl_q;
      if (fsync_n)
      begin
         cnt_d = '0;
      end
      else
      begin
         sh_d  = {sh_q[WORD_W-3:0], data_in};
         cnt_d = cnt_q + 4'h1;
         if (cnt_q == CNT_LAST)
         begin
            word_d = {sh_q, data_in};
            tgl_d  = ~tgl_q;         // Event crosses as a toggle
            cnt_d  = '0;
         end
      end
   end

   // Link-domain registers
   always_ff @(posedge sclk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_q  <= '0;
         sh_q   <= '0;
         word_q <= '0;
         tgl_q  <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         sh_q   <= sh_d;
         word_q <= word_d;
         tgl_q  <= tgl_d;
      end
   end

   assign word_o     = word_q;
   assign word_tgl_o = tgl_q;
endmodule : dtl_serial_rx
`default_nettype wire

// ==== hw/dtl_top.sv ====
// Functional notes
// - Sign enable high drives sign pin
// - Sign enable low floats sign pin
// - Source bit high routes comparator out
// - Source bit low routes DAC MSB
// - Divide bit: one direct, zero halved
// - Mode high triangle, low sine table
// - Two 28-bit tunings, two 12-bit offsets
// - Accumulator adds tuning, wraps 2^28
// - Add selected phase offset, 4096 steps
// - Source bit picks pins or bits
// - Pin change may shift one cycle
// - Codes 01/10 load tuning words
// - Full load: LSB write then MSB
// - Half mode: half bit picks half
// - Code 00 updates control bits
// - Tuning writes take effect at once
// - Select bits at positions 11, 10
// - Code 11 loads phase offset
`timescale 1ns/100ps
`default_nettype none
module dtl_top
   import dtl_pkg::*;
#(
   parameter int ACC_BITS = dtl_pkg::ACC_W,
   parameter int DAC_BITS = dtl_pkg::DAC_W
)
(
   input  wire logic                        clk,
   input  wire logic                        nrst,
   input  wire logic                        ce,
   input  wire logic                        sclk,
   input  wire logic                        fsync_n,
   input  wire logic                        serial_data_in,
   input  wire logic                        freq_select_pin,
   input  wire logic                        phase_select_pin,
   input  wire logic                        comp_in,
   output var  logic [dtl_pkg::DAC_W-1:0]   dac_code,
   output var  logic                        sign_out,
   output var  logic                        sign_out_oe,
   output var  logic [dtl_pkg::ACC_W-1:0]   selected_tuning_value,
   output var  logic [dtl_pkg::PHASE_W-1:0] selected_phase_value
);
   import dtl_pkg::*;

   // Only the documented widths are served
   if (ACC_BITS != ACC_W || DAC_BITS != DAC_W)
   begin : g_bad_width
      $error("dtl_top: unsupported width parameter");
   end

   // Approximate sine shaping of a phase into an offset-binary code
   function automatic logic [DAC_W-1:0] sine_lookup_table(
      input logic [PHASE_W-1:0] ph
   );
      logic [PHASE_W-2:0] x;
      logic [PHASE_W-2:0] xr;
      logic [2*PHASE_W-3:0] prod;
      logic [DAC_W-2:0] amp;
      x    = ph[PHASE_W-2:0];
      xr   = ~x;
      prod = x * xr;
      amp  = prod[SINE_SHIFT+DAC_W-2:SINE_SHIFT];
      if (ph[PHASE_W-1])
         sine_lookup_table = DAC_MID - {1'b0, amp};
      else
         sine_lookup_table = DAC_MID + {1'b0, amp};
   endfunction : sine_lookup_table

   // Linear triangle from the phase, folded at half period
   function automatic logic [DAC_W-1:0] triangle_code(
      input logic [PHASE_W-1:0] ph
   );
      logic [PHASE_W-2:0] f;
      f = ph[PHASE_W-1] ? ~ph[PHASE_W-2:0] : ph[PHASE_W-2:0];
      triangle_code = f[PHASE_W-2:PHASE_W-1-DAC_W];
   endfunction : triangle_code

   // ---- Link receiver, clocked by the link clock
   logic [WORD_W-1:0] rx_word;
   logic              rx_tgl;

   dtl_serial_rx u_rx (
      .sclk       (sclk),
      .nrst       (nrst),
      .fsync_n    (fsync_n),
      .data_in    (serial_data_in),
      .word_o     (rx_word),
      .word_tgl_o (rx_tgl)
   );

   // ---- Word-event crossing into the master clock domain
   logic tgl_s1_q;
   logic tgl_s2_q;
   logic tgl_s3_q;
   logic new_word;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_s3_q <= 1'b0;
      end
      else if (ce)
      begin
         tgl_s1_q <= rx_tgl;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
      end
   end

   // Word bus is stable for sixteen link clocks after each toggle
   assign new_word = ce & (tgl_s2_q ^ tgl_s3_q);

   // ---- Select pins and comparator synchronised on the falling edge
   logic fpin_s1_q;
   logic fpin_s2_q;
   logic ppin_s1_q;
   logic ppin_s2_q;
   logic comp_s1_q;
   logic comp_s2_q;

   always_ff @(negedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fpin_s1_q <= 1'b0;
         fpin_s2_q <= 1'b0;
         ppin_s1_q <= 1'b0;
         ppin_s2_q <= 1'b0;
         comp_s1_q <= 1'b0;
         comp_s2_q <= 1'b0;
      end
      else if (ce)
      begin
         fpin_s1_q <= freq_select_pin;
         fpin_s2_q <= fpin_s1_q;
         ppin_s1_q <= phase_select_pin;
         ppin_s2_q <= ppin_s1_q;
         comp_s1_q <= comp_in;
         comp_s2_q <= comp_s1_q;
      end
   end

   // ---- Register file: control word, tuning words, phase offsets
   logic [WORD_W-1:0]  ctrl_q;
   logic [WORD_W-1:0]  ctrl_d;
   logic [ACC_W-1:0]   tune_q  [2];
   logic [ACC_W-1:0]   tune_d  [2];
   logic [PHASE_W-1:0] phoff_q [2];
   logic [PHASE_W-1:0] phoff_d [2];
   dtl_load_e          load_q;
   dtl_load_e          load_d;
   logic [1:0]         cmd;
   logic [HALF_W-1:0]  payload;
   logic               fidx;
   logic               upper;

   assign cmd     = rx_word[CMD_HI:CMD_LO];
   assign payload = rx_word[HALF_W-1:0];
   assign fidx    = (cmd == CMD_FREQ_B);

   // Decode one received word into register updates
   always_comb
   begin
      ctrl_d  = ctrl_q;
      tune_d  = tune_q;
      phoff_d = phoff_q;
      load_d  = load_q;
      upper   = 1'b0;
      if (new_word)
      begin
         case (cmd)
            CMD_CTRL:
            begin
               ctrl_d = rx_word;
               load_d = DTL_LOAD_IDLE;
            end
            CMD_FREQ_A, CMD_FREQ_B:
            begin
               if (ctrl_q[CB_FULL])
               begin
                  // Second write to the same word carries the MSBs
                  upper = (load_q == DTL_LOAD_HIGH_A && !fidx) ||
                          (load_q == DTL_LOAD_HIGH_B && fidx);
                  if (upper)
                     load_d = DTL_LOAD_IDLE;
                  else if (fidx)
                     load_d = DTL_LOAD_HIGH_B;
                  else
                     load_d = DTL_LOAD_HIGH_A;
               end
               else
               begin
                  upper  = ctrl_q[CB_HALF];
                  load_d = DTL_LOAD_IDLE;
               end
               // Each half is written at once, no holding stage
               if (upper)
                  tune_d[fidx][ACC_W-1:HALF_W] = payload;
               else
                  tune_d[fidx][HALF_W-1:0] = payload;
            end
            CMD_PHASE:
            begin
               phoff_d[rx_word[PH_REG]] = rx_word[PHASE_W-1:0];
               load_d = DTL_LOAD_IDLE;
            end
            default:
            begin
               load_d = DTL_LOAD_IDLE;
            end
         endcase
      end
   end

   // Register file storage
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_q  <= CTRL_RST;
         tune_q  <= '{FREQ_RST, FREQ_RST};
         phoff_q <= '{PHASE_RST, PHASE_RST};
         load_q  <= DTL_LOAD_IDLE;
      end
      else if (ce)
      begin
         ctrl_q  <= ctrl_d;
         tune_q  <= tune_d;
         phoff_q <= phoff_d;
         load_q  <= load_d;
      end
   end

   // ---- Register selection: pins or control bits
   logic tsel;
   logic psel;

   always_comb
   begin
      if (ctrl_q[CB_SRC])
      begin
         tsel = fpin_s2_q;
         psel = ppin_s2_q;
      end
      else
      begin
         tsel = ctrl_q[CB_TSEL];
         psel = ctrl_q[CB_PSEL];
      end
   end

   // ---- Phase accumulator and output shaping
   logic [ACC_W-1:0]   acc_q;
   logic [ACC_W-1:0]   acc_d;
   logic [ACC_W-1:0]   stun_q;
   logic [ACC_W-1:0]   stun_d;
   logic [PHASE_W-1:0] sph_q;
   logic [PHASE_W-1:0] sph_d;
   logic [PHASE_W-1:0] phase_sum;
   logic [DAC_W-1:0]   dac_q;
   logic [DAC_W-1:0]   dac_d;

   always_comb
   begin
      stun_d    = tune_q[tsel];
      sph_d     = phoff_q[psel];
      acc_d     = acc_q + tune_q[tsel];
      // One offset unit is one step of 2 pi over 4096
      phase_sum = acc_q[ACC_W-1:ACC_W-PHASE_W] + phoff_q[psel];
      if (ctrl_q[CB_MODE])
         dac_d = triangle_code(phase_sum);
      else
         dac_d = sine_lookup_table(phase_sum);
   end

   // Datapath registers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         acc_q  <= FREQ_RST;
         stun_q <= FREQ_RST;
         sph_q  <= PHASE_RST;
         dac_q  <= DAC_MID;
      end
      else if (ce)
      begin
         acc_q  <= acc_d;
         stun_q <= stun_d;
         sph_q  <= sph_d;
         dac_q  <= dac_d;
      end
   end

   // ---- Sign output: DAC MSB, halved MSB, or comparator
   logic msb_prev_q;
   logic msb_prev_d;
   logic half_q;
   logic half_d;
   logic sign_q;
   logic sign_d;
   logic oe_q;
   logic oe_d;

   always_comb
   begin
      msb_prev_d = dac_q[DAC_W-1];
      half_d     = half_q;
      // Halved MSB flips on each rising edge of the MSB
      if (dac_q[DAC_W-1] && !msb_prev_q)
         half_d = ~half_q;
      oe_d   = ctrl_q[CB_SOE];
      sign_d = 1'b0;
      if (ctrl_q[CB_SOE])
      begin
         if (ctrl_q[CB_SSRC])
            sign_d = comp_s2_q;
         else if (ctrl_q[CB_DIV])
            sign_d = dac_q[DAC_W-1];
         else
            sign_d = half_q;
      end
   end

   // Sign output registers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         msb_prev_q <= 1'b0;
         half_q     <= 1'b0;
         sign_q     <= 1'b0;
         oe_q       <= 1'b0;
      end
      else if (ce)
      begin
         msb_prev_q <= msb_prev_d;
         half_q     <= half_d;
         sign_q     <= sign_d;
         oe_q       <= oe_d;
      end
   end

   // Outputs, all from flip-flops
   assign dac_code              = dac_q;
   assign sign_out              = sign_q;
   assign sign_out_oe           = oe_q;
   assign selected_tuning_value = stun_q;
   assign selected_phase_value  = sph_q;
endmodule : dtl_top
`default_nettype wire
